// ### hdl/uerr_pkg.sv
// Package with register map, field layout and types for the uncorrectable error block
package uerr_pkg;

    localparam int ADDR_W = 12;
    localparam int NUM_HDR_DW = 4;

    localparam logic [11:0] OFS_UNCORR_STATUS = 12'h104;
    localparam logic [11:0] OFS_UNCORR_MASK = 12'h108;
    localparam logic [11:0] OFS_UNCORR_SEVERITY = 12'h10c;
    localparam logic [11:0] OFS_HDR_LOG0 = 12'h11c;
    localparam logic [11:0] OFS_FIRST_ERR = 12'h118;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h180;
    localparam logic [11:0] OFS_IRQ_CLEAR = 12'h184;
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h188;

    // Supported error bits
    localparam int BIT_TRAINING = 0;
    localparam int BIT_DLL_PROTO = 4;
    localparam int BIT_POISONED = 12;
    localparam int BIT_FC_PROTO = 13;
    localparam int BIT_CPL_TIMEOUT = 14;
    localparam int BIT_CPL_ABORT = 15;
    localparam int BIT_UNEXP_CPL = 16;
    localparam int BIT_RX_OVERFLOW = 17;
    localparam int BIT_MALFORMED = 18;
    localparam int BIT_ECRC = 19;
    localparam int BIT_UNSUP_REQ = 20;
    localparam int BIT_ACS = 21;

    localparam logic [31:0] UERR_IMPL_MASK = 32'h003f_f011;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] SEVERITY_RESET = 32'h0006_2011;

    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_BIT_ERROR = 0;
    localparam int IRQ_BIT_FATAL = 1;
    localparam int IRQ_BIT_NONFATAL = 2;

    typedef enum logic [1:0] {
        MSG_NONE,
        MSG_NONFATAL,
        MSG_FATAL
    } msg_kind_t;

    typedef struct packed {
        logic valid;
        msg_kind_t kind;
        logic [4:0] err_bit;
    } err_msg_t;

    typedef struct packed {
        logic [31:0] dw0;
        logic [31:0] dw1;
        logic [31:0] dw2;
        logic [31:0] dw3;
    } tlp_hdr_t;

    function automatic logic [4:0] lowest_set(input logic [31:0] v);
        logic [4:0] idx;
        idx = 5'd0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

endpackage

// ### hdl/uerr_apb_slave.sv
// APB slave front end: decodes a transfer into one-cycle write and read strobes
`timescale 1ns/1ps
module uerr_apb_slave
    import uerr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] rd_value,
    input wire logic rd_hit,
    output logic wr_stb,
    output logic rd_stb,
    output logic [ADDR_W-1:0] addr,
    output logic [31:0] wdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata
);
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic access;

    // Answers one cycle into the access phase; the done cycle is the pready edge
    assign access = psel && penable && !pready;
    assign wr_stb = access && pwrite;
    assign rd_stb = access && !pwrite;
    assign addr = paddr;
    assign wdata = pwdata;

    always_comb begin
        next_pready = access;
        next_pslverr = access && !rd_hit;
        next_prdata = (rd_stb && rd_hit) ? rd_value : 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end
endmodule

// ### hdl/uerr_hdr_log.sv
// Header log: captures four header doublewords of the first logged error
`timescale 1ns/1ps
module uerr_hdr_log
    import uerr_pkg::*;
(
    input wire logic pclk,
    input wire logic sticky_rstn,
    input wire logic capture,
    input wire tlp_hdr_t hdr_in,
    input wire logic [1:0] rd_idx,
    output logic [31:0] rd_dw
);
    logic [31:0] log_mem [NUM_HDR_DW];
    logic [31:0] next_mem [NUM_HDR_DW];

    always_comb begin
        for (int i = 0; i < NUM_HDR_DW; i++) begin
            next_mem[i] = log_mem[i];
        end
        if (capture) begin
            // Header bytes arrive big-endian, byte 0 in bits 31:24
            next_mem[0] = hdr_in.dw0;
            next_mem[1] = hdr_in.dw1;
            next_mem[2] = hdr_in.dw2;
            next_mem[3] = hdr_in.dw3;
        end
    end

    always_ff @(posedge pclk or negedge sticky_rstn) begin
        if (!sticky_rstn) begin
            for (int i = 0; i < NUM_HDR_DW; i++) begin
                log_mem[i] <= 32'h0000_0000;
            end
        end else begin
            for (int i = 0; i < NUM_HDR_DW; i++) begin
                log_mem[i] <= next_mem[i];
            end
        end
    end

    assign rd_dw = log_mem[rd_idx];
endmodule

// ### hdl/uncorr_error_mask_severity.sv
// Uncorrectable error mask, severity, status and reporting block with APB registers
// Summary of operation
// R1: Mask bit 0 set keeps a training error out of the header log and error messages.
// R2: Mask bit 4 set keeps a data link protocol error out of the log and messages.
// R3: Mask bit 12 set keeps a poisoned packet, received or generated, out of log and messages.
// R4: Mask bit 13 set keeps a flow control protocol error out of log and messages.
// R5: Mask bit 14 set keeps a completion timeout out of log and messages.
// R6: Mask bit 15 set keeps a completer abort out of log and messages.
// R7: Mask bit 16 set keeps an unexpected completion out of log and messages.
// R8: Mask bit 17 set keeps a receiver overflow out of log and messages.
// R9: Mask bit 18 set keeps a malformed packet out of log and messages.
// R10: Mask bit 19 set keeps an end-to-end CRC error out of log and messages.
// R11: Mask bit 20 set keeps an unsupported request out of log and messages.
// R12: Each supported error has a sticky writable severity bit, one meaning fatal.
// R13: Each error sets its own write-one-to-clear sticky status bit.
// R14: An unmasked error arriving while the log is free captures four header doublewords in big-endian byte order.
// R15: Unmasked errors in one cycle send one message, fatal if any of them is fatal, else non-fatal; status is unmasked.
// R16: Reserved mask and severity bits read zero, ignore writes and affect nothing.
`timescale 1ns/1ps
module uncorr_error_mask_severity
    import uerr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sticky_rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic [31:0] err_event,
    input wire tlp_hdr_t err_hdr,
    output err_msg_t err_msg,
    output logic irq
);
    logic wr_stb;
    logic rd_stb;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rd_value;
    logic rd_hit;
    logic [31:0] hdr_dw;

    logic [31:0] mask_reg;
    logic [31:0] sev_reg;
    logic [31:0] status_reg;
    logic [4:0] first_ptr;
    logic log_valid;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;

    logic [31:0] next_mask;
    logic [31:0] next_sev;
    logic [31:0] next_status;
    logic [4:0] next_first_ptr;
    logic next_log_valid;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] next_irq_enable;
    err_msg_t next_err_msg;
    logic next_irq;

    logic [31:0] events;
    logic [31:0] reportable;
    logic [31:0] fatal_ev;
    logic [31:0] nonfatal_ev;
    logic capture;
    logic [4:0] ev_idx;
    logic log_release;

    uerr_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .rd_value(rd_value),
        .rd_hit(rd_hit),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .addr(addr),
        .wdata(wdata),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata)
    );

    // Only implemented error bits take part
    assign events = err_event & UERR_IMPL_MASK; // R16
    // A set mask bit removes the error from logging and messaging
    assign reportable = events & ~mask_reg; // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 R11
    assign fatal_ev = reportable & sev_reg; // R12
    assign nonfatal_ev = reportable & ~sev_reg; // R12
    assign ev_idx = lowest_set(reportable);
    // Clearing the logged error's status frees the log at once, so a new error still lands
    assign log_release = wr_stb && (addr == OFS_UNCORR_STATUS) && wdata[first_ptr];
    // Log only while the log is free, so the first error's header is kept
    assign capture = (|reportable) && (!log_valid || log_release); // R14

    uerr_hdr_log u_log (
        .pclk(pclk),
        .sticky_rstn(sticky_rstn),
        .capture(capture),
        .hdr_in(err_hdr),
        .rd_idx(2'(addr[3:2] - OFS_HDR_LOG0[3:2])),
        .rd_dw(hdr_dw)
    );

    // Register read mux
    always_comb begin
        rd_value = 32'h0000_0000;
        rd_hit = 1'b1;
        case (addr)
            OFS_UNCORR_STATUS: rd_value = status_reg;
            OFS_UNCORR_MASK: rd_value = mask_reg; // R16
            OFS_UNCORR_SEVERITY: rd_value = sev_reg; // R16
            OFS_FIRST_ERR: rd_value = {27'h000_0000, first_ptr};
            OFS_HDR_LOG0, OFS_HDR_LOG0 + 12'h004, OFS_HDR_LOG0 + 12'h008,
            OFS_HDR_LOG0 + 12'h00c: rd_value = hdr_dw; // R14
            OFS_IRQ_STATUS: rd_value = {{(32-IRQ_W){1'b0}}, irq_status};
            OFS_IRQ_CLEAR: rd_value = 32'h0000_0000;
            OFS_IRQ_ENABLE: rd_value = {{(32-IRQ_W){1'b0}}, irq_enable};
            default: rd_hit = 1'b0;
        endcase
    end

    // Sticky error state: mask, severity, status, log pointer
    always_comb begin
        next_mask = mask_reg;
        next_sev = sev_reg;
        next_status = status_reg;
        next_first_ptr = first_ptr;
        next_log_valid = log_valid;
        if (wr_stb && addr == OFS_UNCORR_MASK) begin
            next_mask = wdata & UERR_IMPL_MASK; // R16
        end
        if (wr_stb && addr == OFS_UNCORR_SEVERITY) begin
            next_sev = wdata & UERR_IMPL_MASK; // R12 R16
        end
        if (wr_stb && addr == OFS_UNCORR_STATUS) begin
            next_status = status_reg & ~(wdata & UERR_IMPL_MASK); // R13
            // Clearing the logged error's status frees the log
            if (wdata[first_ptr]) begin
                next_log_valid = 1'b0;
            end
        end
        // New events win over a simultaneous clear
        next_status = next_status | events; // R13 R15
        if (capture) begin
            next_first_ptr = ev_idx;
            next_log_valid = 1'b1; // R14
        end
    end

    always_ff @(posedge pclk or negedge sticky_rstn) begin
        if (!sticky_rstn) begin
            mask_reg <= MASK_RESET;
            sev_reg <= SEVERITY_RESET;
            status_reg <= 32'h0000_0000;
            first_ptr <= 5'd0;
            log_valid <= 1'b0;
        end else begin
            mask_reg <= next_mask;
            sev_reg <= next_sev;
            status_reg <= next_status;
            first_ptr <= next_first_ptr;
            log_valid <= next_log_valid;
        end
    end

    // Error message and interrupt state
    always_comb begin
        next_err_msg.valid = |reportable; // R15
        next_err_msg.err_bit = ev_idx;
        if (|fatal_ev) begin
            next_err_msg.kind = MSG_FATAL; // R15
        end else if (|nonfatal_ev) begin
            next_err_msg.kind = MSG_NONFATAL; // R15
        end else begin
            next_err_msg.kind = MSG_NONE;
        end
        next_irq_enable = irq_enable;
        next_irq_status = irq_status;
        if (wr_stb && addr == OFS_IRQ_ENABLE) begin
            next_irq_enable = wdata[IRQ_W-1:0];
        end
        if (wr_stb && addr == OFS_IRQ_CLEAR) begin
            next_irq_status = irq_status & ~wdata[IRQ_W-1:0];
        end
        next_irq_status[IRQ_BIT_ERROR] = next_irq_status[IRQ_BIT_ERROR] | (|events);
        next_irq_status[IRQ_BIT_FATAL] = next_irq_status[IRQ_BIT_FATAL] | (|fatal_ev);
        next_irq_status[IRQ_BIT_NONFATAL] = next_irq_status[IRQ_BIT_NONFATAL] | (|nonfatal_ev);
        next_irq = |(next_irq_status & next_irq_enable);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_msg <= '0;
            irq_status <= '0;
            irq_enable <= '0;
            irq <= 1'b0;
        end else begin
            err_msg <= next_err_msg;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            irq <= next_irq;
        end
    end
endmodule

// ### tb/uerr_sva.sv
// Checker for the APB answer and error message behaviour
`timescale 1ns/1ps
module uerr_sva
    import uerr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic [31:0] err_event,
    input wire err_msg_t err_msg
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after access cycle");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    slverr_with_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    prdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    msg_cause_a: assert property
        (err_msg.valid |-> ($past(err_event) & (32'h1 << err_msg.err_bit)) != 32'h0000_0000)
        else $error("message without its event");
    no_event_msg_a: assert property
        ((err_event & UERR_IMPL_MASK) == 32'h0000_0000 |=> !err_msg.valid)
        else $error("message without any event");
    msg_kind_a: assert property
        (err_msg.valid |-> err_msg.kind inside {MSG_FATAL, MSG_NONFATAL})
        else $error("message kind empty");
    msg_bit_impl_a: assert property (err_msg.valid |-> UERR_IMPL_MASK[err_msg.err_bit])
        else $error("message for reserved bit");
    cover property (err_msg.valid && err_msg.kind == MSG_FATAL);
    cover property (err_msg.valid && err_msg.kind == MSG_NONFATAL);
    cover property (pslverr);
endmodule
bind uncorr_error_mask_severity uerr_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .err_event(err_event), .err_msg(err_msg));

// ### tb/uerr_rc_model.sv
// Root complex model counting received error messages
`timescale 1ns/1ps
module uerr_rc_model
    import uerr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire err_msg_t err_msg
);
    int fatal_cnt = 0;
    int nonfatal_cnt = 0;
    always @(posedge pclk) begin
        if (presetn && err_msg.valid === 1'b1) begin
            if (err_msg.kind === MSG_FATAL) begin
                fatal_cnt++;
            end else begin
                nonfatal_cnt++;
            end
        end
    end
endmodule

// ### tb/uncorr_error_mask_severity_tb_top.sv
// Testbench for the uncorrectable error mask and severity block
`timescale 1ns/1ps
module uncorr_error_mask_severity_tb_top
    import uerr_pkg::*;
;
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
    logic pclk, presetn, sticky_rstn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, err_event, rd, mk, sv, um, ev;
    tlp_hdr_t err_hdr, hd;
    err_msg_t err_msg;
    int mismatches = 0;
    int checked = 0;
    int exp_fatal = 0;
    int exp_nonfatal = 0;
    int lo;
    int seed = 32'h579a84d7;
    uncorr_error_mask_severity i_dut (.pclk(pclk), .presetn(presetn), .sticky_rstn(sticky_rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .err_event(err_event),
        .err_hdr(err_hdr), .err_msg(err_msg), .irq(irq));
    uerr_rc_model i_rc (.pclk(pclk), .presetn(presetn), .err_msg(err_msg));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic fire(input logic [31:0] e);
        um = e & UERR_IMPL_MASK & ~mk;
        lo = 0;
        for (int i = 31; i >= 0; i--) if (um[i]) lo = i;
        hd = {$random(seed), $random(seed), $random(seed), $random(seed)};
        @(posedge pclk);
        err_event <= e;
        err_hdr <= hd;
        @(posedge pclk);
        err_event <= 32'h0000_0000;
        @(negedge pclk);
        `CHK("msg_valid", um != 0, err_msg.valid)
        if (um != 0) begin
            `CHK("msg_kind", (um & sv) != 0 ? MSG_FATAL : MSG_NONFATAL, err_msg.kind)
            `CHK("msg_bit", 5'(lo), err_msg.err_bit)
            if ((um & sv) != 0) exp_fatal++;
            else exp_nonfatal++;
        end
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, err_event, err_hdr} = '0;
        presetn = 1'b0;
        sticky_rstn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        sticky_rstn <= 1'b1;
        apb(0, OFS_UNCORR_MASK, 0);
        `CHK("mask_rst", MASK_RESET, rd)
        apb(0, OFS_UNCORR_SEVERITY, 0);
        `CHK("sev_rst", SEVERITY_RESET, rd)
        sv = SEVERITY_RESET;
        apb(1, OFS_UNCORR_MASK, 32'hffff_ffff);
        apb(0, OFS_UNCORR_MASK, 0);
        `CHK("mask_rw", UERR_IMPL_MASK, rd)
        mk = UERR_IMPL_MASK;
        fire(UERR_IMPL_MASK);
        apb(0, OFS_UNCORR_STATUS, 0);
        `CHK("status_masked", UERR_IMPL_MASK, rd)
        sv = $random(seed);
        apb(1, OFS_UNCORR_SEVERITY, sv);
        sv &= UERR_IMPL_MASK;
        apb(0, OFS_UNCORR_SEVERITY, 0);
        `CHK("sev_rw", sv, rd)
        apb(0, 12'h000, 0);
        `CHK("unmapped_err", 1'b1, er)
        `CHK("unmapped_rd", 32'h0000_0000, rd)
        apb(1, OFS_IRQ_ENABLE, 32'h0000_0007);
        apb(1, OFS_UNCORR_STATUS, 32'hffff_ffff);
        apb(1, OFS_IRQ_CLEAR, 32'h0000_0007);
        for (int b = 0; b < 32; b++) if (UERR_IMPL_MASK[b]) begin
            ev = (32'h1 << b) | ((b % 2) ? ($random(seed) & UERR_IMPL_MASK) : 0);
            mk = $random(seed);
            apb(1, OFS_UNCORR_MASK, mk);
            mk &= UERR_IMPL_MASK;
            fire(ev);
            apb(0, OFS_UNCORR_STATUS, 0);
            `CHK("status", ev, rd)
            `CHK("irq_on", 1'b1, irq)
            apb(0, OFS_IRQ_STATUS, 0);
            `CHK("irq_cause", {29'h000_0000, (um & ~sv) != 0, (um & sv) != 0, 1'b1}, rd)
            if (um != 0) begin
                apb(0, OFS_FIRST_ERR, 0);
                `CHK("first_ptr", 32'(lo), rd)
            end
            if (um != 0) for (int k = 0; k < NUM_HDR_DW; k++) begin
                apb(0, OFS_HDR_LOG0 + 12'(4 * k), 0);
                `CHK("hdr_log", hd[127 - 32 * k -: 32], rd)
            end
            apb(1, OFS_UNCORR_STATUS, ev);
            apb(1, OFS_IRQ_CLEAR, 32'h0000_0007);
            `CHK("irq_clr", 1'b0, irq)
        end
        apb(0, OFS_UNCORR_STATUS, 0);
        `CHK("status_clr", 32'h0000_0000, rd)
        apb(1, OFS_IRQ_CLEAR, 32'h0000_0007);
        apb(1, OFS_IRQ_ENABLE, 32'h0000_0000);
        fire(32'h1 << BIT_ACS);
        repeat (2) @(negedge pclk);
        `CHK("irq_off", 1'b0, irq)
        apb(0, OFS_IRQ_STATUS, 0);
        `CHK("irq_status", 1'b1, rd[IRQ_BIT_ERROR])
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_UNCORR_MASK, 0);
        `CHK("mask_sticky", mk, rd)
        apb(0, OFS_UNCORR_SEVERITY, 0);
        `CHK("sev_sticky", sv, rd)
        apb(0, OFS_UNCORR_STATUS, 0);
        `CHK("status_sticky", 32'h1 << BIT_ACS, rd)
        `CHK("fatal_cnt", exp_fatal, i_rc.fatal_cnt)
        `CHK("nonfatal_cnt", exp_nonfatal, i_rc.nonfatal_cnt)
        conclude();
    end
endmodule
